// [bench/adc_irq_mux_scan_regs_tb.sv]
module adc_irq_mux_scan_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  lockCode = 8'hA5;
  logic [1:0]  convModeSel = 2'h0;
  logic        resultReady = 1'b0, resultRead = 1'b0, checkError = 1'b0;
  logic        porEvent = 1'b0, startEvent = 1'b0, otherEvent = 1'b0;
  logic        bitstreamIn = 1'b0, modTick = 1'b1, convDone = 1'b0;
  logic        lastInCycle = 1'b0, wrEn, rdEn, pinOut, pinOeN;
  logic        bitstreamToResult, fastCmdEnable, scanStart;
  logic [3:0]  addr, posInputSel, negInputSel;
  logic [15:0] scanChannels;
  logic [23:0] wrData, rdData, offsetTrim, gainTrim, rv;
  logic [23:0] m [16];
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cnt, a;

  airq_host u_host (.clk, .rdData, .wrEn, .rdEn, .addr, .wrData);
  airq_regs u_airq_regs (.clk, .nrst, .ce, .wrEn, .rdEn, .addr, .wrData,
    .lockCode, .convModeSel, .resultReady, .resultRead, .checkError,
    .porEvent, .startEvent, .otherEvent, .bitstreamIn, .modTick, .convDone,
    .lastInCycle, .rdData, .pinOut, .pinOeN, .bitstreamToResult,
    .fastCmdEnable, .posInputSel, .negInputSel, .scanChannels, .offsetTrim,
    .gainTrim, .scanStart);

  initial forever #5 clk = ~clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic initM;
    for (int i = 0; i < 16; i++)
      m[i] = 24'h000000;
    m[5] = 24'h000073;
    m[6] = 24'h000001;
    m[10] = 24'h800000;
    m[11] = 24'h900000;
  endtask

  task automatic mw(input logic [3:0] ad, input logic [23:0] d);
    if (lockCode == airq_pkg::UNLOCK_CODE && ce)
      case (ad)
        4'h5: m[5][3:0] = d[3:0];
        4'h6: m[6] = {16'h0000, d[7:0]};
        4'h7: m[7] = d & 24'hE0FFFF;
        4'h8, 4'h9, 4'hA: m[ad] = d;
        default: ;
      endcase
    u_host.wr(ad, d);
  endtask

  task automatic rchk(input logic [3:0] ad);
    u_host.rd(ad, rv);
    cmp(rv, m[ad]);
  endtask

  task automatic allRegs;
    for (int i = 5; i < 12; i++)
      rchk(i[3:0]);
  endtask

  task automatic outs;
    repeat (2) @(negedge clk);
    cmp({15'h0, fastCmdEnable, posInputSel, negInputSel},
        {15'h0, m[5][1], m[6][7:0]});
    cmp({8'h00, scanChannels}, {8'h00, m[7][15:0]});
    cmp(offsetTrim, m[9]);
    cmp(gainTrim, m[10]);
  endtask

  task automatic pin(input logic [3:0] cfg, input logic oth, bs, ck,
                     input logic [1:0] e);
    mw(4'h5, {20'h00000, cfg});
    otherEvent = oth;
    bitstreamIn = bs;
    checkError = ck;
    m[5][5] = ~ck;
    repeat (5) @(negedge clk);
    cmp({22'h0, pinOeN, pinOut | pinOeN}, {22'h0, e});
    cmp({23'h0, bitstreamToResult}, {23'h0, cfg[3]});
    rchk(4'h5);
  endtask

  task automatic gap(input logic last, input int n);
    lastInCycle = last;
    convDone = 1'b1;
    @(negedge clk);
    convDone = 1'b0;
    lastInCycle = 1'b0;
    cnt = 0;
    while (scanStart !== 1'b1 && cnt < 2000)
    begin
      @(negedge clk);
      cnt++;
    end
    if (cnt >= 2000)
    begin
      n_mismatch++;
      give_verdict;
    end
    else
      cmp({23'h0, cnt >= n && cnt <= n + 3}, 24'h000001);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    initM;
    void'($urandom(32'h541f));
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    allRegs;
    outs;
    repeat (30)
    begin
      a = 5 + $urandom % 7;
      mw(a[3:0], 24'($urandom));
      rchk(a[3:0]);
      outs;
    end
    mw(4'h6, 24'h0000DE);
    outs;
    mw(4'hC, 24'hFFFFFF);
    mw(4'h5, 24'hFFFFFF);
    lockCode = 8'h3C;
    mw(4'h8, 24'h123456);
    lockCode = 8'hA5;
    ce = 1'b0;
    mw(4'h9, 24'h654321);
    ce = 1'b1;
    allRegs;
    resultReady = 1'b1;
    @(negedge clk);
    resultReady = 1'b0;
    m[5][6] = 1'b0;
    rchk(4'h5);
    resultRead = 1'b1;
    @(negedge clk);
    resultRead = 1'b0;
    m[5][6] = 1'b1;
    rchk(4'h5);
    porEvent = 1'b1;
    repeat (3) @(negedge clk);
    porEvent = 1'b0;
    repeat (3) @(negedge clk);
    m[5][4] = 1'b0;
    rchk(4'h5);
    m[5][4] = 1'b1;
    rchk(4'h5);
    pin(4'b0010, 1'b0, 1'b0, 1'b0, 2'b11);
    pin(4'b0110, 1'b0, 1'b0, 1'b0, 2'b01);
    pin(4'b0010, 1'b1, 1'b0, 1'b0, 2'b00);
    pin(4'b1110, 1'b1, 1'b1, 1'b0, 2'b01);
    pin(4'b1010, 1'b0, 1'b0, 1'b0, 2'b00);
    pin(4'b1110, 1'b0, 1'b1, 1'b1, 2'b00);
    for (int e = 0; e < 2; e++)
    begin
      pin({3'b001, e[0]}, 1'b0, 1'b0, 1'b0, 2'b11);
      startEvent = 1'b1;
      cnt = 0;
      repeat (6)
      begin
        @(negedge clk);
        startEvent = 1'b0;
        if (pinOeN === 1'b0 && pinOut === 1'b0)
          cnt++;
      end
      cmp({23'h0, cnt > 0}, {23'h0, e[0]});
    end
    convModeSel = 2'h3;
    for (int k = 0; k < 8; k++)
    begin
      mw(4'h7, {k[2:0], 21'h000000});
      gap(1'b0, (k == 0) ? 0 : (8 << (k - 1)));
    end
    mw(4'h8, 24'h000028);
    gap(1'b1, 40);
    mw(4'h8, 24'h000000);
    gap(1'b1, 0);
    // single-shot mode: the last conversion must not restart the scan
    convModeSel = 2'h0;
    lastInCycle = 1'b1;
    convDone = 1'b1;
    @(negedge clk);
    convDone = 1'b0;
    lastInCycle = 1'b0;
    cnt = 0;
    repeat (8)
    begin
      @(negedge clk);
      if (scanStart !== 1'b0)
        cnt++;
    end
    cmp(24'(cnt), 24'h000000);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    initM;
    allRegs;
    outs;
    give_verdict;
  end
endmodule

// [bench/airq_host.sv]
// host side of the register port: one strobe per request, held over
// the sampling edge and released at the following falling edge
module airq_host (
  input  wire logic        clk,
  input  wire logic [23:0] rdData,
  output logic             wrEn = 1'b0,
  output logic             rdEn = 1'b0,
  output logic [3:0]       addr = 4'h0,
  output logic [23:0]      wrData = 24'h000000
);
  timeunit 1ns;
  timeprecision 1ps;

  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    logic [23:0] v;
    v = d;
    if (a == 4'h7)
      v[20] = 1'b0;
    if (a == 4'hB)
      v = 24'h900000;
    @(negedge clk);
    addr = a;
    wrData = v;
    wrEn = 1'b1;
    @(negedge clk);
    wrEn = 1'b0;
    wrData = ~v;
  endtask

  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    @(negedge clk);
    addr = a;
    rdEn = 1'b1;
    @(negedge clk);
    rdEn = 1'b0;
    d = rdData;
  endtask
endmodule

// [logic/airq_pkg.sv]
package airq_pkg;
  // register addresses
  localparam logic [3:0] ADDR_INT   = 4'h5;
  localparam logic [3:0] ADDR_MUX   = 4'h6;
  localparam logic [3:0] ADDR_SCAN  = 4'h7;
  localparam logic [3:0] ADDR_TMR   = 4'h8;
  localparam logic [3:0] ADDR_OFS   = 4'h9;
  localparam logic [3:0] ADDR_GAIN  = 4'hA;
  localparam logic [3:0] ADDR_RSVB  = 4'hB;
  localparam logic [3:0] ADDR_LOCK  = 4'hD;
  // interrupt register fields
  localparam int BIT_FRESH   = 6;
  localparam int BIT_CHKERR  = 5;
  localparam int BIT_POR     = 4;
  localparam int BIT_PINSEL  = 3;
  localparam int BIT_PINDRV  = 2;
  localparam int BIT_FASTCMD = 1;
  localparam int BIT_STARTEN = 0;
  // scan register fields
  localparam int SCAN_GAP_LSB = 21;
  localparam int SCAN_RSV_BIT = 20;
  // reset values
  localparam logic [3:0]  RST_INT_CFG = 4'h3;
  localparam logic [7:0]  RST_MUX     = 8'h01;
  localparam logic [23:0] RST_SCAN    = 24'h000000;
  localparam logic [23:0] RST_TMR     = 24'h000000;
  localparam logic [23:0] RST_OFS     = 24'h000000;
  localparam logic [23:0] RST_GAIN    = 24'h800000;
  localparam logic [23:0] RST_RSVB    = 24'h900000;
  localparam logic [7:0]  RST_LOCK    = 8'hA5;
  localparam logic [7:0]  UNLOCK_CODE = 8'hA5;
  localparam logic [1:0]  MODE_CONT   = 2'h3;
  // scan gap base: 8 modulator clocks, shifted by code-1
  localparam int GAP_BASE_CLKS = 8;
endpackage

// [logic/airq_regs.sv]
// ----------------------------------------
// register bank, addresses 0x5 to 0xB
// ----------------------------------------
// Operation
// - fresh-result flag low until result read
// - check error flag low on error
// - power-on flag low until register read
// - pin select 1: bitstream, por/crc override
// - pin select 0: active-low interrupt, all
// - drive bit (pin select 0): high driven, else released when idle
// - modes 1x put bitstream in result
// - bit 1 enables fast commands
// - bit 0 enables conversion start pulse
// - bits 7-4 select positive input
// - bits 3-0 select negative input
// - scan gap code gives 0..512 clocks
// - scan bits 19-16 read zero
// - timer sets gap between scan cycles
// - offset trim is signed, reset zero
// - gain trim unsigned, reset 0x800000
// - interrupt bit 7 reads zero
// - mode 11 repeats scan cycles
// - writes only when lock holds 0xA5
module airq_regs (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        wrEn,
  input  wire logic        rdEn,
  input  wire logic [3:0]  addr,
  input  wire logic [23:0] wrData,
  input  wire logic [7:0]  lockCode,
  input  wire logic [1:0]  convModeSel,
  input  wire logic        resultReady,
  input  wire logic        resultRead,
  input  wire logic        checkError,
  input  wire logic        porEvent,
  input  wire logic        startEvent,
  input  wire logic        otherEvent,
  input  wire logic        bitstreamIn,
  input  wire logic        modTick,
  input  wire logic        convDone,
  input  wire logic        lastInCycle,
  output logic [23:0]      rdData,
  output logic             pinOut,
  output logic             pinOeN,
  output logic             bitstreamToResult,
  output logic             fastCmdEnable,
  output logic [3:0]       posInputSel,
  output logic [3:0]       negInputSel,
  output logic [15:0]      scanChannels,
  output logic [23:0]      offsetTrim,
  output logic [23:0]      gainTrim,
  output logic             scanStart
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic        freshN_ff;
  logic        chkErrN_ff;
  logic        porN_ff;
  logic [3:0]  intCfg_ff;
  logic [7:0]  mux_ff;
  logic [3:0]  scanHi_ff;
  logic [15:0] scanCh_ff;
  logic [23:0] tmr_ff;
  logic [23:0] ofs_ff;
  logic [23:0] gain_ff;
  logic [23:0] rsvb_ff;
  logic        porSync1_ff;
  logic        porSync2_ff;
  logic        chkSync1_ff;
  logic        chkSync2_ff;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  wire unlocked  = (lockCode == airq_pkg::UNLOCK_CODE);
  wire wrOk      = wrEn && unlocked;
  wire wrInt     = wrOk && hit(addr, airq_pkg::ADDR_INT);
  wire wrMux     = wrOk && hit(addr, airq_pkg::ADDR_MUX);
  wire wrScan    = wrOk && hit(addr, airq_pkg::ADDR_SCAN);
  wire wrTmr     = wrOk && hit(addr, airq_pkg::ADDR_TMR);
  wire wrOfs     = wrOk && hit(addr, airq_pkg::ADDR_OFS);
  wire wrGain    = wrOk && hit(addr, airq_pkg::ADDR_GAIN);
  wire wrRsvb    = wrOk && hit(addr, airq_pkg::ADDR_RSVB);
  wire rdInt     = rdEn && hit(addr, airq_pkg::ADDR_INT);
  wire pinSel    = intCfg_ff[airq_pkg::BIT_PINSEL];
  wire pinDrv    = intCfg_ff[airq_pkg::BIT_PINDRV];
  wire startOk   = intCfg_ff[airq_pkg::BIT_STARTEN];
  wire contMode  = (convModeSel == airq_pkg::MODE_CONT);

  // interrupt register image, bit 7 zero
  wire [7:0] intImg = {1'b0, freshN_ff, chkErrN_ff, porN_ff,
                       intCfg_ff};

  logic [23:0] rdMux;
  always_comb
  begin
    unique case (addr)
      airq_pkg::ADDR_INT:  rdMux = {16'h0000, intImg};
      airq_pkg::ADDR_MUX:  rdMux = {16'h0000, mux_ff};
      airq_pkg::ADDR_SCAN: rdMux = {scanHi_ff, 4'h0, scanCh_ff};
      airq_pkg::ADDR_TMR:  rdMux = tmr_ff;
      airq_pkg::ADDR_OFS:  rdMux = ofs_ff;
      airq_pkg::ADDR_GAIN: rdMux = gain_ff;
      airq_pkg::ADDR_RSVB: rdMux = rsvb_ff;
      default:             rdMux = 24'h000000;
    endcase
  end

  // ----------------------------------------
  // pin: por/crc always, all sources in irq mode
  // ----------------------------------------
  wire sevIrq  = !porN_ff || !chkErrN_ff;
  wire anyIrq  = sevIrq || !freshN_ff || (startEvent && startOk)
                 || otherEvent;
  wire irqAct  = pinSel ? sevIrq : anyIrq;
  wire pinLvl  = irqAct ? 1'b0 : (pinSel ? bitstreamIn : 1'b1);
  // released only when idle, in irq mode, drive bit clear
  wire pinRel  = !irqAct && !pinSel && !pinDrv;

  // ----------------------------------------
  // flags and control
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      porSync1_ff <= 1'b0;
      porSync2_ff <= 1'b0;
      chkSync1_ff <= 1'b0;
      chkSync2_ff <= 1'b0;
    end
    else if (ce)
    begin
      porSync1_ff <= porEvent;
      porSync2_ff <= porSync1_ff;
      chkSync1_ff <= checkError;
      chkSync2_ff <= chkSync1_ff;
    end
  end

  // set beats clear in the fresh and power-on flags; check error follows its synchronizer
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      freshN_ff  <= 1'b1;
      chkErrN_ff <= 1'b1;
      porN_ff    <= 1'b1;
    end
    else if (ce)
    begin
      if (resultReady)
        freshN_ff <= 1'b0;
      else if (resultRead)
        freshN_ff <= 1'b1;
      chkErrN_ff <= !chkSync2_ff;
      if (porSync2_ff)
        porN_ff <= 1'b0;
      else if (rdInt)
        porN_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      intCfg_ff <= airq_pkg::RST_INT_CFG;
      mux_ff    <= airq_pkg::RST_MUX;
      scanHi_ff <= airq_pkg::RST_SCAN[23:20];
      scanCh_ff <= airq_pkg::RST_SCAN[15:0];
      tmr_ff    <= airq_pkg::RST_TMR;
      ofs_ff    <= airq_pkg::RST_OFS;
      gain_ff   <= airq_pkg::RST_GAIN;
      rsvb_ff   <= airq_pkg::RST_RSVB;
    end
    else if (ce)
    begin
      if (wrInt)
        intCfg_ff <= wrData[3:0];
      if (wrMux)
        mux_ff <= wrData[7:0];
      if (wrScan)
      begin
        scanHi_ff <= wrData[23:20];
        scanCh_ff <= wrData[15:0];
      end
      if (wrTmr)
        tmr_ff <= wrData;
      if (wrOfs)
        ofs_ff <= wrData;
      if (wrGain)
        gain_ff <= wrData;
      if (wrRsvb)
        rsvb_ff <= wrData;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rdData            <= 24'h000000;
      pinOut            <= 1'b1;
      pinOeN            <= 1'b1;
      bitstreamToResult <= 1'b0;
      fastCmdEnable     <= 1'b1;
      posInputSel       <= airq_pkg::RST_MUX[7:4];
      negInputSel       <= airq_pkg::RST_MUX[3:0];
      scanChannels      <= 16'h0000;
      offsetTrim        <= 24'h000000;
      gainTrim          <= airq_pkg::RST_GAIN;
    end
    else if (ce)
    begin
      rdData            <= rdMux;
      pinOut            <= pinLvl;
      pinOeN            <= pinRel;
      bitstreamToResult <= pinSel;
      fastCmdEnable     <= intCfg_ff[airq_pkg::BIT_FASTCMD];
      posInputSel       <= mux_ff[7:4];
      negInputSel       <= mux_ff[3:0];
      scanChannels      <= scanCh_ff;
      offsetTrim        <= ofs_ff;
      gainTrim          <= gain_ff;
    end
  end

  // ----------------------------------------
  // scan timing
  // ----------------------------------------
  airq_scan_timer #(.CW(24)) u_timer (
    .clk         (clk),
    .nrst        (nrst),
    .ce          (ce),
    .modTick     (modTick),
    .convDone    (convDone),
    .lastInCycle (lastInCycle),
    .contMode    (contMode),
    .gapSel      (scanHi_ff[3:1]),
    .cycleGap    (tmr_ff),
    .startConv   (scanStart)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // mux write stored, then copied to the select outputs
  sequence s_mux_wr;
    ce && wrMux ##1 ce;
  endsequence

  // enabled start event while the pin is in interrupt mode
  sequence s_start_hit;
    ce && startEvent && startOk && !pinSel;
  endsequence

  // start event with the start pulse disabled and nothing else pending
  sequence s_start_quiet;
    ce && startEvent && !startOk && !pinSel && !sevIrq && freshN_ff
    && !otherEvent;
  endsequence

  chk_lock_blocks_write: assert property (@(posedge clk)
    disable iff (!nrst) ce && wrEn && !unlocked
    && addr == airq_pkg::ADDR_MUX |=> $stable(mux_ff))
    else $error("locked write changed mux");
  chk_fresh_flag_set: assert property (@(posedge clk)
    disable iff (!nrst) ce && resultReady |=> !freshN_ff)
    else $error("fresh flag not low after result");
  chk_por_flag_clear: assert property (@(posedge clk)
    disable iff (!nrst) ce && rdInt && !porSync2_ff |=> porN_ff)
    else $error("por flag not released by read");
  chk_por_flag_set: assert property (@(posedge clk)
    disable iff (!nrst) ce && porSync2_ff |=> !porN_ff)
    else $error("por flag not set by event");
  chk_chkerr_follow: assert property (@(posedge clk)
    disable iff (!nrst) ce && chkSync2_ff |=> !chkErrN_ff)
    else $error("check error flag missed");
  chk_bit7_zero: assert property (@(posedge clk)
    disable iff (!nrst)
    $past(ce) && $past(addr) == airq_pkg::ADDR_INT |-> rdData[7] == 1'b0)
    else $error("interrupt bit 7 nonzero");
  chk_scan_unimpl: assert property (@(posedge clk)
    disable iff (!nrst) $past(ce) && $past(addr) == airq_pkg::ADDR_SCAN
    |-> rdData[19:16] == 4'h0)
    else $error("scan bits 19-16 nonzero");
  chk_pin_sev_prio: assert property (@(posedge clk)
    disable iff (!nrst) ce && pinSel && !porN_ff |=> !pinOut && !pinOeN)
    else $error("por did not override bitstream");
  chk_pin_release: assert property (@(posedge clk)
    disable iff (!nrst) ce && !irqAct && !pinSel && !pinDrv |=> pinOeN)
    else $error("idle pin not released");
  chk_status_ro: assert property (@(posedge clk)
    disable iff (!nrst)
    ce && wrInt && !resultReady && !resultRead |=> $stable(freshN_ff))
    else $error("write altered fresh flag");
  chk_fast_follow: assert property (@(posedge clk)
    disable iff (!nrst)
    ce |=> fastCmdEnable == $past(intCfg_ff[airq_pkg::BIT_FASTCMD]))
    else $error("fast command enable stale");
  chk_result_mode: assert property (@(posedge clk)
    disable iff (!nrst)
    ce |=> bitstreamToResult == $past(intCfg_ff[airq_pkg::BIT_PINSEL]))
    else $error("result source does not follow pin mode");
  chk_mux_to_sel: assert property (@(posedge clk)
    disable iff (!nrst) s_mux_wr
    |=> {posInputSel, negInputSel} == $past(wrData[7:0], 2))
    else $error("input select not updated after write");
  chk_start_pulse: assert property (@(posedge clk)
    disable iff (!nrst) s_start_hit |=> !pinOut && !pinOeN)
    else $error("start event did not reach the pin");
  chk_start_masked: assert property (@(posedge clk)
    disable iff (!nrst) s_start_quiet |=> pinOut || pinOeN)
    else $error("disabled start event reached the pin");
endmodule

// [logic/airq_scan_timer.sv]
// times the gap between conversions and between scan cycles
module airq_scan_timer #(
  parameter int CW = 24
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          ce,
  input  wire logic          modTick,
  input  wire logic          convDone,
  input  wire logic          lastInCycle,
  input  wire logic          contMode,
  input  wire logic [2:0]    gapSel,
  input  wire logic [CW-1:0] cycleGap,
  output logic               startConv
);
  // the longest scan gap needs ten counter bits
  if (CW < 10)
  begin
    $error("counter too narrow for 512 clocks");
  end

  logic [CW-1:0] cnt_ff;
  logic          busy_ff;
  logic [CW-1:0] gapLen;
  logic [CW-1:0] loadVal;

  assign gapLen = (gapSel == 3'h0) ? '0 :
      CW'(airq_pkg::GAP_BASE_CLKS) << (gapSel - 3'h1);
  // last conversion waits only in continuous mode
  assign loadVal = lastInCycle ? cycleGap : gapLen;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_ff    <= '0;
      busy_ff   <= 1'b0;
      startConv <= 1'b0;
    end
    else if (ce)
    begin
      startConv <= 1'b0;
      if (convDone && (!lastInCycle || contMode))
      begin
        busy_ff <= 1'b1;
        cnt_ff  <= loadVal;
      end
      else if (busy_ff && cnt_ff == '0)
      begin
        busy_ff   <= 1'b0;
        startConv <= 1'b1;
      end
      else if (busy_ff && modTick)
        cnt_ff <= cnt_ff - CW'(1);
    end
  end
endmodule
